/* File: dhis_regs.vh */
/*
  Constants of the display host interface block: register offsets,
  field positions, reset values and FIFO word layout.
  Assumes inclusion by dhis_top.v and by the test bench; holds definitions and nothing else.
*/
`ifndef DHIS_REGS_VH
`define DHIS_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets (Avalon-MM, one 32-bit word each)
// ----------------------------------------------------------------
`define DHIS_OFS_CTRL 5'h00
`define DHIS_OFS_STATUS 5'h04
`define DHIS_OFS_RXDATA 5'h08
`define DHIS_OFS_TXDATA 5'h0C
`define DHIS_OFS_SYNC 5'h10
`define DHIS_OFS_PIXEL 5'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define DHIS_CTRL_SERIAL_OUT_ENABLE_BIT 0
`define DHIS_CTRL_TE_EN 1
`define DHIS_CTRL_SER_RD 2
`define DHIS_CTRL_RST 3'h0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define DHIS_ST_OVF 4
`define DHIS_ST_EMPTY 5

// ----------------------------------------------------------------
// FIFO word: kind in the top two bits, bus value below
// ----------------------------------------------------------------
`define DHIS_DW 18
`define DHIS_FW 20
`define DHIS_KIND_CMD 2'h0
`define DHIS_KIND_DATA 2'h1
`define DHIS_KIND_PIX 2'h2
`define DHIS_KIND_PIX_SOL 2'h3

// ----------------------------------------------------------------
// Pixel colour fields on the bus
// ----------------------------------------------------------------
`define DHIS_BLUE_LSB 0
`define DHIS_GREEN_LSB 6
`define DHIS_RED_LSB 12

// ----------------------------------------------------------------
// Misc widths and counts
// ----------------------------------------------------------------
`define DHIS_SER_LAST 3'h7
`define DHIS_ZERO32 32'h0000_0000

`endif

/* File: dhis_top.v */
/*
  Display host interface mode select: parallel 16/8-bit bus, serial
  port and RGB pixel input of a display controller, plus an 8-word FIFO
  that hands received words to software over Avalon-MM.
  Assumes all pins are asynchronous to mclk and are much slower than it
  (each strobe level lasts several mclk periods).
*/
// Operation
// - Straps pick 16-bit, 8-bit or RGB+serial
// - Middle strap fixed one, not decoded
// - Chip select high ignores strobes and data
// - Serial bit captured on clock rising edge
// - Serial output driven only when enabled
// - Data/command line tags each transfer
// - Write strobe low phase carries write data
// - Write strobe pin is serial clock
// - Read strobe low drives read data
// - Reset pin low clears all logic but pin synchronisers, Avalon handshake and Avalon read data
// - Data enable qualifies RGB pixels
// - Horizontal sync aligns pixels to lines
// - Vertical sync aligns lines to frames
`timescale 1ns/1ns
`include "dhis_regs.vh"

// ----------------------------------------------------------------
// FIFO with valid/ready on both sides
// ----------------------------------------------------------------
module dhis_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire mclk,
  input wire clr,
  // Fill side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // Drain side
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready,
  // Fill level
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Word storage
  reg [AW:0] wr_ptr; // Write pointer, one extra wrap bit
  reg [AW:0] rd_ptr; // Read pointer, one extra wrap bit
  wire push; // Word accepted
  wire pop; // Word drained

  assign level = wr_ptr - rd_ptr;
  assign in_ready = (level != DEPTH[AW:0] + {AW+1{1'b0}}) && !level[AW];
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers and storage
  always @(posedge mclk) begin
    if (clr) begin
      wr_ptr <= {AW+1{1'b0}};
      rd_ptr <= {AW+1{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr[AW-1:0]] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // dhis_fifo

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module dhis_top (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Avalon-MM slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Mode straps and device reset pin
  input wire mode_strap_low,
  input wire mode_strap_high,
  input wire reset_pin_n,
  // Bus control pins
  input wire chip_select_n,
  input wire data_command_select,
  input wire write_strobe_serial_clock,
  input wire read_strobe_n,
  // Data bus, two-way
  input wire [17:0] bus_in,
  output reg [17:0] bus_out,
  output reg bus_oe,
  // Serial data, two-way, and serial output
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output reg serial_data_out,
  // RGB inputs
  input wire pixel_clock,
  input wire data_enable,
  input wire hsync,
  input wire vsync,
  // Tearing effect
  output reg tear_effect_out
);
  // Interface modes, one-hot
  localparam MODE_P16 = 4'b0001;
  localparam MODE_P8 = 4'b0010;
  localparam MODE_RGB = 4'b0100;
  localparam MODE_NONE = 4'b1000;

  // Pack colour fields, blue low, red high
  function [17:0] dhis_pix;
    input [17:0] b;
    begin
      dhis_pix = {b[`DHIS_RED_LSB+5:`DHIS_RED_LSB],
                  b[`DHIS_GREEN_LSB+5:`DHIS_GREEN_LSB],
                  b[`DHIS_BLUE_LSB+5:`DHIS_BLUE_LSB]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [29:0] pin_raw; // All asynchronous inputs
  reg [29:0] pin_s1; // First stage, read only by pin_s2
  reg [29:0] pin_s2; // Stable copy
  reg [29:0] pin_s3; // Previous value for edges

  assign pin_raw = {bus_in, sda_in, vsync, hsync, data_enable, pixel_clock,
                    reset_pin_n, read_strobe_n, write_strobe_serial_clock,
                    data_command_select, chip_select_n, mode_strap_high,
                    mode_strap_low};

  // Two flip-flops before any logic, third for edge detection
  always @(posedge mclk) begin
    if (!rst_n) begin
      pin_s1 <= 30'h0000_0000;
      pin_s2 <= 30'h0000_0000;
      pin_s3 <= 30'h0000_0000;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  wire s_low = pin_s2[0]; // Lower strap
  wire s_high = pin_s2[1]; // Upper strap
  wire cs_n = pin_s2[2]; // Chip select
  wire dc = pin_s2[3]; // High for data
  wire wr = pin_s2[4]; // Write strobe / serial clock
  wire rd_n = pin_s2[5]; // Read strobe
  wire pin_rst_n = pin_s2[6]; // Device reset pin
  wire pclk_rise = pin_s2[7] && !pin_s3[7]; // Pixel clock edge
  wire de = pin_s2[8]; // Data enable
  wire hs_fall = !pin_s2[9] && pin_s3[9]; // Line start
  wire vs = pin_s2[10]; // Vertical sync, low active
  wire vs_fall = !pin_s2[10] && pin_s3[10]; // Frame start
  wire sda = pin_s2[11]; // Serial data in
  wire [17:0] bus = pin_s2[29:12]; // Data bus
  wire wr_rise = wr && !pin_s3[4]; // Strobe or clock rising
  wire wr_fall = !wr && pin_s3[4]; // Serial clock falling
  wire cs_fall = !cs_n && pin_s3[2]; // Start of access

  // Clear from either reset; synchronisers and Avalon handshake use rst_n only
  wire clr = !rst_n || !pin_rst_n;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  reg [3:0] mode; // Current interface mode

  // Middle strap is fixed high inside, so only two straps are read
  always @(posedge mclk) begin
    if (clr) begin
      mode <= MODE_NONE;
    end else begin
      case ({s_high, s_low})
        2'b00: mode <= MODE_P16;
        2'b01: mode <= MODE_P8;
        2'b11: mode <= MODE_RGB;
        default: mode <= MODE_NONE; // Undefined strap pair
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  reg [2:0] ctrl; // Output enable, tear enable, serial read arm
  reg [17:0] txdata; // Value returned on host reads
  reg overflow; // Sticky: word lost on full FIFO
  reg [15:0] line_cnt; // Lines since frame start
  reg [7:0] frame_cnt; // Frames seen
  reg [17:0] last_pix; // Most recent pixel, colour packed

  // ----------------------------------------------------------------
  // Capture into FIFO
  // ----------------------------------------------------------------
  reg in_valid; // Word ready for FIFO
  reg [19:0] in_data; // Kind and value
  reg sol; // Next pixel starts a line
  reg [2:0] ser_cnt; // Serial bit counter
  reg [7:0] ser_sh; // Serial shift in
  reg [7:0] tx_sh; // Serial shift out
  wire in_ready; // FIFO has room
  wire out_valid; // FIFO holds a word
  wire [19:0] out_data; // Head word
  wire [3:0] level; // Fill level
  wire pop; // Software read of RXDATA
  wire par = (mode == MODE_P16) || (mode == MODE_P8);
  wire [1:0] kind = dc ? `DHIS_KIND_DATA : `DHIS_KIND_CMD;
  wire [17:0] par_val = (mode == MODE_P8) ? {10'h000, bus[7:0]} : bus;

  // Parallel, serial and pixel capture; RGB mode has both serial and pixel, pixel wins a tie
  always @(posedge mclk) begin
    if (clr) begin
      in_valid <= 1'b0;
      in_data <= 20'h0_0000;
      ser_cnt <= 3'h0;
      ser_sh <= 8'h00;
      tx_sh <= 8'h00;
      sol <= 1'b0;
      line_cnt <= 16'h0000;
      frame_cnt <= 8'h00;
      last_pix <= 18'h0_0000;
    end else begin
      in_valid <= 1'b0;
      if (cs_n) begin
        ser_cnt <= 3'h0;
      end
      // Write strobe rising closes the low phase; data held across it
      if (par && !cs_n && wr_rise) begin
        in_valid <= 1'b1;
        in_data <= {kind, par_val};
      end
      // Serial mode: strobe pin is the clock
      if (mode == MODE_RGB && !cs_n) begin
        if (cs_fall) begin
          tx_sh <= txdata[7:0];
        end
        if (wr_rise) begin
          ser_sh <= {ser_sh[6:0], sda};
          ser_cnt <= ser_cnt + 3'h1;
          if (ser_cnt == `DHIS_SER_LAST) begin
            in_valid <= 1'b1;
            in_data <= {kind, 10'h000, ser_sh[6:0], sda};
          end
        end
        if (wr_fall) begin
          tx_sh <= {tx_sh[6:0], 1'b0};
        end
      end
      // RGB pixels, sync counters
      if (mode == MODE_RGB) begin
        if (pclk_rise && de) begin
          in_valid <= 1'b1;
          in_data <= {sol ? `DHIS_KIND_PIX_SOL : `DHIS_KIND_PIX, bus};
          last_pix <= dhis_pix(bus);
          sol <= 1'b0;
        end
        if (hs_fall) begin
          sol <= 1'b1;
          line_cnt <= line_cnt + 16'h0001;
        end
        if (vs_fall) begin
          line_cnt <= 16'h0000;
          frame_cnt <= frame_cnt + 8'h01;
        end
      end
    end
  end

  // Eight-word buffer between pins and software
  dhis_fifo #(
    .WIDTH(`DHIS_FW),
    .DEPTH(8),
    .AW(3)
  ) u_fifo (
    .mclk(mclk),
    .clr(clr),
    .in_valid(in_valid),
    .in_data(in_data),
    .in_ready(in_ready),
    .out_valid(out_valid),
    .out_data(out_data),
    .out_ready(pop),
    .level(level)
  );

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Bus driven only during a selected read; output bit by mode
  always @(posedge mclk) begin
    if (clr) begin
      bus_out <= 18'h0_0000;
      bus_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      serial_data_out <= 1'b0;
      tear_effect_out <= 1'b0;
    end else begin
      bus_oe <= par && !cs_n && !rd_n;
      bus_out <= (mode == MODE_P8) ? {10'h000, txdata[7:0]} : txdata;
      // Enabled: dedicated pin; otherwise shared data line if armed
      serial_data_out <= ctrl[`DHIS_CTRL_SERIAL_OUT_ENABLE_BIT] & tx_sh[7];
      sda_oe <= (mode == MODE_RGB) && !cs_n && ctrl[`DHIS_CTRL_SER_RD]
                && !ctrl[`DHIS_CTRL_SERIAL_OUT_ENABLE_BIT];
      sda_out <= tx_sh[7];
      // Tear signal follows the vertical sync pulse
      tear_effect_out <= ctrl[`DHIS_CTRL_TE_EN] && !vs;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave: answer one cycle after the request
  // ----------------------------------------------------------------
  wire req = (avs_read || avs_write) && avs_waitrequest;
  wire wr_hit = avs_write && !avs_waitrequest; // Write lands at the answer edge
  assign pop = avs_read && avs_waitrequest
               && (avs_address == `DHIS_OFS_RXDATA);

  // Handshake and read data
  always @(posedge mclk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `DHIS_ZERO32;
    end else begin
      avs_waitrequest <= !req;
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `DHIS_OFS_CTRL: avs_readdata <= {29'h0000_0000, ctrl};
          `DHIS_OFS_STATUS: avs_readdata <= {26'h000_0000, !out_valid,
                                            overflow, level};
          `DHIS_OFS_RXDATA: avs_readdata <= {12'h000, out_data};
          `DHIS_OFS_TXDATA: avs_readdata <= {14'h0000, txdata};
          `DHIS_OFS_SYNC: avs_readdata <= {8'h00, frame_cnt, line_cnt};
          `DHIS_OFS_PIXEL: avs_readdata <= {14'h0000, last_pix};
          default: avs_readdata <= `DHIS_ZERO32; // Unmapped
        endcase
      end
    end
  end

  // Writable registers; lost word sets overflow, set beats clear
  always @(posedge mclk) begin
    if (clr) begin
      ctrl <= `DHIS_CTRL_RST;
      txdata <= 18'h0_0000;
      overflow <= 1'b0;
    end else begin
      if (wr_hit && avs_address == `DHIS_OFS_CTRL) begin
        ctrl <= avs_writedata[2:0];
      end
      if (wr_hit && avs_address == `DHIS_OFS_TXDATA) begin
        txdata <= avs_writedata[17:0];
      end
      if (in_valid && !in_ready) begin
        overflow <= 1'b1;
      end else if (wr_hit && avs_address == `DHIS_OFS_STATUS
                   && avs_writedata[`DHIS_ST_OVF]) begin
        overflow <= 1'b0;
      end
    end
  end
endmodule // dhis_top

/* File: dhis_top_sva.sv */
/* Checker for dhis_top: watches top-level ports only.
   Assumes the single clock mclk and synchronous reset rst_n. */
`timescale 1ns/1ns
module dhis_top_sva (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Register bus handshake
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // Pins
  input wire mode_strap_high,
  input wire reset_pin_n,
  input wire chip_select_n,
  input wire read_strobe_n,
  input wire vsync,
  input wire bus_oe,
  input wire sda_oe,
  input wire tear_effect_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Answer comes exactly one cycle after the request is taken
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered next cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // Reset itself must not be masked here
  reset_quiet_a: assert property (
    disable iff (1'b0) !rst_n |=> avs_waitrequest && !bus_oe && !sda_oe && !tear_effect_out)
    else $error("outputs not cleared by reset");
  pin_reset_a: assert property (
    !reset_pin_n [*4] |-> !bus_oe && !tear_effect_out) else $error("pin reset ignored");
  // Synchroniser delay is three cycles, so six is a safe bound
  desel_idle_a: assert property (
    chip_select_n [*6] |-> !bus_oe && !sda_oe) else $error("driving while deselected");
  read_drive_a: assert property (
    (!chip_select_n && !read_strobe_n && !mode_strap_high) [*6] |-> bus_oe)
    else $error("bus not driven during read");
  read_release_a: assert property (
    read_strobe_n [*5] |-> !bus_oe) else $error("bus driven without read strobe");
  rgb_mode_a: assert property (
    mode_strap_high [*6] |-> !bus_oe) else $error("bus driven outside parallel mode");
  tear_idle_a: assert property (
    vsync [*5] |-> !tear_effect_out) else $error("tear output without vsync");
  cover property (avs_read && !avs_waitrequest);
  cover property ($rose(bus_oe));
  cover property ($rose(tear_effect_out));
endmodule // dhis_top_sva
bind dhis_top dhis_top_sva dhis_top_sva_inst (.mclk, .rst_n, .avs_read, .avs_write,
  .avs_waitrequest, .mode_strap_high, .reset_pin_n, .chip_select_n, .read_strobe_n,
  .vsync, .bus_oe, .sda_oe, .tear_effect_out);

/* File: dhis_host_model.sv */
/* Host model: drives the pin side of the display interface.
   Assumes mclk from the bench; every time is counted in mclk periods. */
`timescale 1ns/1ns
module dhis_host_model (
  // Clock and what the host reads back
  input wire mclk,
  input wire [17:0] bus,
  input wire serial_data_out,
  // Selects and strobes
  output reg chip_select_n = 1,
  output reg data_command_select = 0,
  output reg write_strobe_serial_clock = 1,
  output reg read_strobe_n = 1,
  // Data and RGB lines
  output reg [17:0] host_val = 0,
  output reg host_sda = 0,
  output reg pixel_clock = 0,
  output reg data_enable = 0,
  output reg hsync = 1,
  output reg vsync = 1
);
  task wt(input int n); repeat (n) @(posedge mclk); endtask
  // One strobed word; cs given so a deselected write can be tried
  task par_write(input logic dc, input logic [17:0] v, input logic cs);
    chip_select_n <= cs;
    data_command_select <= dc;
    host_val <= v;
    wt(4);
    write_strobe_serial_clock <= 0;
    wt(6);
    write_strobe_serial_clock <= 1;
    wt(6);
    chip_select_n <= 1;
    host_val <= ~v; // Released lines show no stale value
    wt(4);
  endtask
  task par_read(output logic [17:0] v);
    chip_select_n <= 0;
    wt(2);
    read_strobe_n <= 0;
    wt(10);
    v = bus;
    read_strobe_n <= 1;
    wt(8);
    chip_select_n <= 1;
    wt(4);
  endtask
  // Clock idles low in a frame and stands still outside it
  task ser_byte(input logic dc, input logic [7:0] b, output logic [7:0] got);
    write_strobe_serial_clock <= 0;
    data_command_select <= dc;
    wt(4);
    chip_select_n <= 0;
    for (int i = 7; i >= 0; i--) begin
      host_sda <= b[i];
      wt(20);
      got[i] = serial_data_out;
      write_strobe_serial_clock <= 1;
      wt(20);
      write_strobe_serial_clock <= 0;
    end
    wt(4);
    chip_select_n <= 1;
    host_sda <= ~b[0];
    wt(4);
    write_strobe_serial_clock <= 1;
    wt(4);
  endtask
  task pix(input logic [17:0] v, input logic de);
    host_val <= v;
    data_enable <= de;
    wt(20);
    pixel_clock <= 1;
    wt(16); // High 16, low 24: a 40-cycle link clock
    pixel_clock <= 0;
    data_enable <= 0;
    host_val <= ~v;
    wt(4);
  endtask
  task sync(input logic frame);
    if (frame) vsync <= 0;
    else hsync <= 0;
    wt(12);
    vsync <= 1;
    hsync <= 1;
    wt(10);
  endtask
endmodule // dhis_host_model

/* File: dhis_top_test.sv */
/* Bench for dhis_top: Avalon tasks, host pin model, one task per scenario.
   Assumes the design, the host model and the checker are compiled first. */
`timescale 1ns/1ns
`include "dhis_regs.vh"
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t %s", $time, m); end end
module dhis_top_test;
  // Clock, reset and register bus
  logic mclk = 0;
  logic rst_n = 0;
  logic [4:0] avs_address = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  // Straps and device reset pin
  logic mode_strap_low = 0;
  logic mode_strap_high = 0;
  logic reset_pin_n = 0;
  // Pins between host model and device
  wire chip_select_n, data_command_select, write_strobe_serial_clock, read_strobe_n;
  wire host_sda, sda_out, sda_oe, serial_data_out, pixel_clock, data_enable, hsync, vsync;
  wire bus_oe, tear_effect_out;
  wire [17:0] host_val, bus_out;
  // Shared lines: the device wins only while it enables its driver
  wire [17:0] bus = bus_oe ? bus_out : host_val;
  wire sda = sda_oe ? sda_out : host_sda;
  int miscompares = 0;
  int compares = 0;
  logic [31:0] rd;
  logic [17:0] pv;
  logic [7:0] sb;
  always #2 mclk = ~mclk;
  dhis_top dhis_top_inst (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .mode_strap_low, .mode_strap_high, .reset_pin_n,
    .chip_select_n, .data_command_select, .write_strobe_serial_clock, .read_strobe_n,
    .bus_in(bus), .bus_out, .bus_oe, .sda_in(sda), .sda_out, .sda_oe, .serial_data_out,
    .pixel_clock, .data_enable, .hsync, .vsync, .tear_effect_out);
  dhis_host_model dhis_host_model_inst (.mclk, .bus, .serial_data_out, .chip_select_n,
    .data_command_select, .write_strobe_serial_clock, .read_strobe_n, .host_val, .host_sda,
    .pixel_clock, .data_enable, .hsync, .vsync);
  task wt(input int n); repeat (n) @(posedge mclk); endtask
  // Holds the request until waitrequest is sampled low
  task av(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge mclk);
  endtask
  task rdchk(input logic [4:0] a, input logic [31:0] e);
    av(0, a, 0);
    `CHK(rd, e, "register read")
  endtask
  task rx(input logic [19:0] e);
    av(0, `DHIS_OFS_RXDATA, 0);
    `CHK(rd[19:0], e, "received word")
  endtask
  task t_reset;
    rdchk(`DHIS_OFS_STATUS, 32'h0000_0020);
    rdchk(`DHIS_OFS_CTRL, 32'h0000_0000);
    av(1, 5'h18, 32'hFFFF_FFFF);
    rdchk(5'h18, 32'h0000_0000);
    $display("test reset done");
  endtask
  task t_par16;
    dhis_host_model_inst.par_write(0, 18'h0_1234, 0);
    dhis_host_model_inst.par_write(1, 18'h0_BEEF, 0);
    dhis_host_model_inst.par_write(1, 18'h0_0777, 1);
    rx(20'h0_1234);
    rx(20'h4_BEEF);
    rdchk(`DHIS_OFS_STATUS, 32'h0000_0020);
    av(1, `DHIS_OFS_TXDATA, 32'h0000_5A5A);
    dhis_host_model_inst.par_read(pv);
    `CHK(pv[15:0], 16'h5A5A, "16-bit read")
    $display("test par16 done");
  endtask
  task t_par8;
    mode_strap_low <= 1;
    wt(8);
    dhis_host_model_inst.par_write(1, 18'h0_12C3, 0);
    rx(20'h4_00C3);
    dhis_host_model_inst.par_read(pv);
    `CHK(pv[7:0], 8'h5A, "8-bit read")
    mode_strap_low <= 0;
    mode_strap_high <= 1;
    wt(8);
    dhis_host_model_inst.par_write(1, 18'h0_0055, 0);
    rdchk(`DHIS_OFS_STATUS, 32'h0000_0020);
    mode_strap_high <= 0;
    wt(8);
    $display("test par8 done");
  endtask
  task t_fifo;
    for (int i = 0; i < 9; i++) dhis_host_model_inst.par_write(1, 18'(i), 0);
    rdchk(`DHIS_OFS_STATUS, 32'h0000_0018);
    for (int i = 0; i < 8; i++) rx({2'h1, 18'(i)});
    rdchk(`DHIS_OFS_STATUS, 32'h0000_0030);
    av(1, `DHIS_OFS_STATUS, 32'h0000_0010);
    rdchk(`DHIS_OFS_STATUS, 32'h0000_0020);
    $display("test fifo done");
  endtask
  task t_pin;
    dhis_host_model_inst.par_write(1, 18'h0_0001, 0);
    av(1, `DHIS_OFS_CTRL, 32'h0000_0001);
    reset_pin_n <= 0;
    wt(8);
    reset_pin_n <= 1;
    wt(8);
    rdchk(`DHIS_OFS_STATUS, 32'h0000_0020);
    rdchk(`DHIS_OFS_CTRL, 32'h0000_0000);
    $display("test pin reset done");
  endtask
  task t_serial;
    mode_strap_low <= 1;
    mode_strap_high <= 1;
    wt(8);
    av(1, `DHIS_OFS_CTRL, 32'h0000_0001);
    av(1, `DHIS_OFS_TXDATA, 32'h0000_00A5);
    dhis_host_model_inst.ser_byte(1, 8'h3C, sb);
    `CHK(sb, 8'hA5, "serial output byte")
    rx(20'h4_003C);
    dhis_host_model_inst.ser_byte(0, 8'hC3, sb);
    rx(20'h0_00C3);
    // Armed read with the dedicated pin off: device owns the shared line
    av(1, `DHIS_OFS_CTRL, 32'h0000_0004);
    dhis_host_model_inst.ser_byte(1, 8'h00, sb);
    `CHK(sb, 8'h00, "serial output while disabled")
    rx(20'h4_00A5);
    $display("test serial done");
  endtask
  task t_rgb;
    av(1, `DHIS_OFS_CTRL, 32'h0000_0002);
    fork
      dhis_host_model_inst.sync(1);
    join_none
    wt(8);
    `CHK(tear_effect_out, 1'b1, "tear during vsync")
    wt(20);
    dhis_host_model_inst.sync(0);
    dhis_host_model_inst.pix(18'h3_F041, 1);
    dhis_host_model_inst.pix(18'h2_2222, 0);
    dhis_host_model_inst.pix(18'h0_0FC0, 1);
    rx(20'hF_F041);
    rx(20'h8_0FC0);
    rdchk(`DHIS_OFS_PIXEL, 32'h0000_0FC0);
    rdchk(`DHIS_OFS_SYNC, 32'h0001_0001);
    $display("test rgb done");
  endtask
  task complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Host resets the device before any transfer
  initial begin
    wt(12);
    rst_n <= 1;
    reset_pin_n <= 1;
    wt(6);
    t_reset;
    t_par16;
    t_par8;
    t_fifo;
    t_pin;
    t_serial;
    t_rgb;
    complete_run;
  end
  // Watchdog: tests need under two thousand cycles
  initial begin
    wt(20000);
    miscompares++;
    complete_run;
  end
endmodule // dhis_top_test
